// ---- rtl/sbsr_consts.svh ----
// Offsets, field positions, reset values and masks for the status byte block
`ifndef SBSR_CONSTS_SVH
`define SBSR_CONSTS_SVH
`define SBSR_ADR_STB        4'h0
`define SBSR_ADR_SRE        4'h1
`define SBSR_ADR_ESR        4'h2
`define SBSR_ADR_ESE        4'h3
`define SBSR_ADR_AMP        4'h4
`define SBSR_ADR_AMPE       4'h5
`define SBSR_ADR_ERR        4'h6
`define SBSR_ADR_ERROR_ENABLE_WRITE       4'h7
`define SBSR_ADR_POLL       4'h8
`define SBSR_ADR_CTRL       4'h9
`define SBSR_ADR_ADDR       4'hA
`define SBSR_ADR_IRQ_ST     4'hB
`define SBSR_ADR_IRQ_MSK    4'hC
`define SBSR_BIT_ERR        2
`define SBSR_BIT_AMP        3
`define SBSR_BIT_ESB        5
`define SBSR_BIT_RQS        6
`define SBSR_ESR_IQO        0
`define SBSR_ESR_OQO        2
`define SBSR_ESR_EXE        4
`define SBSR_ESR_CMD        5
`define SBSR_ESR_URQ        6
`define SBSR_ESR_PON        7
`define SBSR_AMP_IFO        5
`define SBSR_ESR_MASK       8'hF5
`define SBSR_AMP_MASK       16'h0FFB
`define SBSR_ERR_MASK       8'hFE
`define SBSR_ADDR_DEF       5'h08
`define SBSR_CTRL_CLS       0
`define SBSR_CTRL_ADDR_RST  1
`define SBSR_IRQ_SRQ        0
`define SBSR_IRQ_QCLR       1
`endif

// ---- rtl/sbsr_pkg.sv ----
// Types shared by the status byte block
package sbsr_pkg;
    typedef struct packed {
        logic [7:0]  std;
        logic [15:0] amp;
        logic [7:0]  err;
    } sbsr_events_t;
    typedef enum logic [1:0] {
        SBSR_BUS_IDLE = 2'b01,
        SBSR_BUS_ACK  = 2'b10
    } sbsr_bus_t;
endpackage

// ---- rtl/sbsr_status_byte.sv ----
// Serial poll status byte, event registers and service request logic
//
// Behaviour
// - Serial poll changes only request-service bit
// - First poll after request reports one, clears
// - Later polls report zero until new request
// - Status byte query clears nothing, follows conditions
// - Query request bit is OR of enabled
// - Summary bit set when event AND enable
// - Summary stays until enabled events cleared
// - Event query clears it; clear-status clears all
// - Request only on enabled bit rising edge
// - Steady enabled bit gives exactly one request
// - Enable masks written one to one, except SRE bit six kept zero
// - Request-service flag at bit six, poll-reset
// - Amplifier summary bit three, overload bit five
// - Amplifier query clears overload, may re-request
// - Bus address defaults and resets to eight
// - Standard event bit layout; overflows clear queues
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "sbsr_consts.svh"
module sbsr_status_byte #(
    parameter int AMP_W = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [5:2]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    output logic                    wb_err_o,
    input  wire sbsr_pkg::sbsr_events_t ev_set,
    input  wire logic               serial_poll,
    input  wire logic [7:0]         stb_low_bits,
    output logic      [7:0]         poll_byte,
    output logic                    srq_out,
    output logic                    queue_clear,
    output logic      [4:0]         bus_address,
    output logic                    irq
);
    logic [7:0]          std_r;
    logic [7:0]          ese_r;
    logic [7:0]          err_r;
    logic [7:0]          error_enable_write_r;
    logic [7:0]          sre_r;
    logic [AMP_W-1:0]    amp_r;
    logic [AMP_W-1:0]    ampe_r;
    logic [7:0]          stb_base;
    logic [7:0]          stb_prev_r;
    logic [7:0]          stb_query;
    logic                req_pend_r;
    logic                srq_evt;
    logic [1:0]          irq_st_r;
    logic [1:0]          irq_msk_r;
    logic [1:0]          irq_evt;
    logic [4:0]          addr_r;
    logic                ack_r;
    logic                acc;
    logic                wr;
    logic                rd;
    logic [3:0]          adr;
    logic [7:0]          new_rise;
    logic                cls;
    logic                adr_rst;
    logic                std_clr;
    logic                amp_clr;
    logic                err_clr;
    logic                irq_clr;
    logic [7:0]          std_set;
    logic [AMP_W-1:0]    amp_set;
    logic [7:0]          err_set;
    sbsr_pkg::sbsr_bus_t bus_st_r;

    // Reads clear on the taking edge, so only the first cycle of a request acts
    assign acc = wb_cyc_i && wb_stb_i && !ack_r && !wb_err_o;
    assign wr  = acc && wb_we_i;
    assign rd  = acc && !wb_we_i;
    assign adr = wb_adr_i;

    function automatic logic hit(input logic [3:0] a);
        return rd && (adr == a);
    endfunction

    function automatic logic wr_hit(input logic [3:0] a);
        return wr && (adr == a) && wb_sel_i[0];
    endfunction

    // Kept in a process: an assign would not wake on what the functions read
    always_comb
    begin
        cls     = wr_hit(`SBSR_ADR_CTRL) && wb_dat_i[`SBSR_CTRL_CLS];
        adr_rst = wr_hit(`SBSR_ADR_CTRL) && wb_dat_i[`SBSR_CTRL_ADDR_RST];
        std_clr = cls || hit(`SBSR_ADR_ESR);
        amp_clr = cls || hit(`SBSR_ADR_AMP);
        err_clr = cls || hit(`SBSR_ADR_ERR);
        irq_clr = hit(`SBSR_ADR_IRQ_ST);
    end

    // Unused positions are masked here so they can never latch
    assign std_set = ev_set.std & `SBSR_ESR_MASK;
    assign amp_set = ev_set.amp[AMP_W-1:0] & AMP_W'(`SBSR_AMP_MASK);
    assign err_set = ev_set.err & `SBSR_ERR_MASK;

    always_comb
    begin
        stb_base = stb_low_bits;
        // Positions 2, 3, 5 and 6 of the low input are overridden below
        stb_base[`SBSR_BIT_RQS] = 1'b0;
        // held while any enabled bit is set
        stb_base[`SBSR_BIT_ESB] = |(std_r & ese_r);
        stb_base[`SBSR_BIT_AMP] = |(amp_r & ampe_r);
        stb_base[`SBSR_BIT_ERR] = |(err_r & error_enable_write_r);
        stb_query = stb_base;
        stb_query[`SBSR_BIT_RQS] = |(stb_base & sre_r);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_rise
            assign new_rise[gi] = stb_base[gi] & sre_r[gi] & ~stb_prev_r[gi];
        end
    endgenerate
    assign srq_evt  = |new_rise;

    // registered copy for edge detection
    // Taken on byte AND enable, so enabling a set bit also requests
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            stb_prev_r <= 8'h00;
        else
            stb_prev_r <= stb_base & sre_r;
    end

    // one pending request per rising edge
    // first poll sees it and clears it
    // later polls report zero
    // A rise in the poll cycle wins, so that request is not lost
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            req_pend_r <= 1'b0;
        else if (srq_evt)
            req_pend_r <= 1'b1;
        else if (serial_poll)
            req_pend_r <= 1'b0;
    end

    // poll alters only the request bit
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            poll_byte <= 8'h00;
        else if (serial_poll)
            poll_byte <= stb_base | ({7'h00, req_pend_r} << `SBSR_BIT_RQS);
    end

    // The bus request line is the pending flag itself
    assign srq_out = req_pend_r;

    // standard event sources; overflows clear queues
    // Registered, so the flush lands one cycle after the overflow
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            queue_clear <= 1'b0;
        else
            queue_clear <= ev_set.std[`SBSR_ESR_IQO] | ev_set.std[`SBSR_ESR_OQO];
    end

    // read clears after returning, set wins
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            std_r <= 8'h00 | (8'h01 << `SBSR_ESR_PON);
        else if (std_clr)
            std_r <= std_set;
        else
            std_r <= std_r | std_set;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            amp_r <= '0;
        else if (amp_clr)
            amp_r <= amp_set;
        else
            amp_r <= amp_r | amp_set;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            err_r <= 8'h00;
        else if (err_clr)
            err_r <= err_set;
        else
            err_r <= err_r | err_set;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sre_r  <= 8'h00;
            ese_r  <= 8'h00;
            error_enable_write_r <= 8'h00;
            ampe_r <= '0;
        end
        else
        begin
            // Request bit itself cannot be enabled
            if (wr_hit(`SBSR_ADR_SRE))
                sre_r <= wb_dat_i[7:0] & ~(8'h01 << `SBSR_BIT_RQS);
            if (wr_hit(`SBSR_ADR_ESE))
                ese_r <= wb_dat_i[7:0];
            if (wr_hit(`SBSR_ADR_ERROR_ENABLE_WRITE))
                error_enable_write_r <= wb_dat_i[7:0];
            // Byte lanes let the low enables be written alone
            if (wr && adr == `SBSR_ADR_AMPE)
            begin
                if (wb_sel_i[0])
                    ampe_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    ampe_r[AMP_W-1:8] <= wb_dat_i[AMP_W-1:8];
            end
        end
    end

    // address defaults to eight and resets to it
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            addr_r <= `SBSR_ADDR_DEF;
        else if (adr_rst)
            addr_r <= `SBSR_ADDR_DEF;
        else if (wr_hit(`SBSR_ADR_ADDR))
            addr_r <= wb_dat_i[4:0];
    end

    assign bus_address = addr_r;

    // Interrupt status: set wins over read clear
    assign irq_evt = {queue_clear, srq_evt};

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_st_r <= 2'b00;
        else if (irq_clr)
            irq_st_r <= irq_evt;
        else
            irq_st_r <= irq_st_r | irq_evt;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_msk_r <= 2'b00;
        else if (wr_hit(`SBSR_ADR_IRQ_MSK))
            irq_msk_r <= wb_dat_i[1:0];
    end

    assign irq = |(irq_st_r & irq_msk_r);

    // Bus answer one cycle after the request; unmapped gets err
    logic mapped;
    assign mapped = (adr <= `SBSR_ADR_IRQ_MSK);

    // Answer state: ack lasts only the single cycle spent in the ack state
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            bus_st_r <= sbsr_pkg::SBSR_BUS_IDLE;
        else
        begin
            case (bus_st_r)
                sbsr_pkg::SBSR_BUS_IDLE:
                begin
                    if (acc && mapped)
                        bus_st_r <= sbsr_pkg::SBSR_BUS_ACK;
                end
                sbsr_pkg::SBSR_BUS_ACK:
                    bus_st_r <= sbsr_pkg::SBSR_BUS_IDLE;
                default:
                    bus_st_r <= sbsr_pkg::SBSR_BUS_IDLE;
            endcase
        end
    end

    // Unmapped index answers with err instead of ack
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            wb_err_o <= 1'b0;
        else
            wb_err_o <= acc && !mapped;
    end

    assign ack_r    = (bus_st_r == sbsr_pkg::SBSR_BUS_ACK);
    assign wb_ack_o = ack_r;

    // status byte query clears nothing
    // Bits above 7 read as zero except bits 15:8 of the amplifier words and bit 8 of the poll word, which carries the pending flag
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            wb_dat_o <= 32'h0000_0000;
        else if (rd)
        begin
            case (adr)
                `SBSR_ADR_STB:     wb_dat_o <= {24'h000000, stb_query};
                `SBSR_ADR_SRE:     wb_dat_o <= {24'h000000, sre_r};
                `SBSR_ADR_ESR:     wb_dat_o <= {24'h000000, std_r};
                `SBSR_ADR_ESE:     wb_dat_o <= {24'h000000, ese_r};
                `SBSR_ADR_AMP:     wb_dat_o <= 32'(amp_r);
                `SBSR_ADR_AMPE:    wb_dat_o <= 32'(ampe_r);
                `SBSR_ADR_ERR:     wb_dat_o <= {24'h000000, err_r};
                `SBSR_ADR_ERROR_ENABLE_WRITE:    wb_dat_o <= {24'h000000, error_enable_write_r};
                `SBSR_ADR_POLL:    wb_dat_o <= {23'h000000, req_pend_r, poll_byte};
                `SBSR_ADR_ADDR:    wb_dat_o <= {27'h0000000, addr_r};
                `SBSR_ADR_IRQ_ST:  wb_dat_o <= {30'h00000000, irq_st_r};
                `SBSR_ADR_IRQ_MSK: wb_dat_o <= {30'h00000000, irq_msk_r};
                default:           wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // sbsr_status_byte

// ---- sim/sbsr_chk_sva.sv ----
// Port-level checker for the status byte block
`timescale 1ns/10ps
module sbsr_chk (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic [5:2] wb_adr_i,
    input wire logic       wb_ack_o,
    input wire logic       wb_err_o,
    input wire logic       serial_poll,
    input wire logic [7:0] poll_byte,
    input wire logic       srq_out,
    input wire logic [4:0] bus_address,
    input wire sbsr_pkg::sbsr_events_t ev_set,
    input wire logic       queue_clear
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    AST_ACK_LAT: assert property (req |=> wb_ack_o || wb_err_o) else $error("no bus answer");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_UNMAPPED: assert property (req && wb_adr_i > 4'hC |=> wb_err_o && !wb_ack_o) else $error("no err");
    AST_POLL_SET: assert property (srq_out && serial_poll |=> poll_byte[6]) else $error("poll lost");
    AST_POLL_ZERO: assert property (!srq_out && serial_poll |=> !poll_byte[6]) else $error("stale");
    AST_POLL_HOLD: assert property (!serial_poll |=> $stable(poll_byte)) else $error("byte moved");
    AST_SRQ_HOLD: assert property (srq_out && !serial_poll |=> srq_out) else $error("srq lost");
    AST_ADDR_RST: assert property ($rose(rst_b) |-> bus_address == 5'h08) else $error("bad address");
    AST_QCLR: assert property (queue_clear == ($past(ev_set.std[0]) || $past(ev_set.std[2]))) else $error("qclr");
endmodule // sbsr_chk
bind sbsr_status_byte sbsr_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .serial_poll(serial_poll), .poll_byte(poll_byte), .srq_out(srq_out), .bus_address(bus_address),
    .ev_set(ev_set), .queue_clear(queue_clear));

// ---- sim/sbsr_host.sv ----
// Bus controller model that serial polls on a service request
`timescale 1ns/10ps
module sbsr_host (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       srq_out,
    input  wire logic       poll_req,
    input  wire logic [3:0] dly,
    output logic            serial_poll
);
    logic [3:0] cnt_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_poll <= 1'b0;
            cnt_r <= 4'h0;
        end
        else if (srq_out && !serial_poll)
        begin
            // Delay comes from dly, fixed for the whole run, so one host speed is seen per seed
            serial_poll <= cnt_r >= dly;
            cnt_r <= (cnt_r >= dly) ? 4'h0 : cnt_r + 4'h1;
        end
        else
            serial_poll <= poll_req;
    end
endmodule // sbsr_host

// ---- sim/tb.sv ----
// Self-checking bench for the status byte block
`timescale 1ns/10ps
`include "sbsr_consts.svh"
module tb;
    logic        ref_clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, poll_req = 0;
    logic [3:0]  adr = 0, dly = 0;
    logic [31:0] dat = 0, dout, m, e;
    logic [7:0]  low = 0, pb;
    logic        ack, err, spoll, srq, qclr, irq;
    logic [4:0]  ba;
    integer      seed = 32'h4AF8;
    int          n_fail = 0, n_tests = 0, cyc_n = 0;
    logic [31:0] expq[$];
    sbsr_pkg::sbsr_events_t ev = '0;
    initial forever #5 ref_clk = ~ref_clk;
    sbsr_status_byte u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .wb_err_o(err), .ev_set(ev), .serial_poll(spoll), .stb_low_bits(low),
        .poll_byte(pb), .srq_out(srq), .queue_clear(qclr), .bus_address(ba), .irq(irq));
    sbsr_host u_host (.ref_clk(ref_clk), .rst_b(rst_b), .srq_out(srq), .poll_req(poll_req),
        .dly(dly), .serial_poll(spoll));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge ref_clk); while (!(ack || err));
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        expq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pulse(input sbsr_pkg::sbsr_events_t x);
        ev <= x;
        @(posedge ref_clk);
        ev <= '0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic wpoll;
        do @(posedge ref_clk); while (!spoll);
        #1;
    endtask
    // Read data is compared against the oldest note
    always @(posedge ref_clk)
        if ((ack || err) && !we && expq.size() > 0)
            chk("rdata", dout, expq.pop_front());
    always @(posedge ref_clk)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        low <= $random(seed) & 8'h93;
        dly <= $random(seed);
        @(posedge ref_clk);
        rd(`SBSR_ADR_ESR, 32'h80);
        rd(`SBSR_ADR_ESR, 32'h0);
        rd(`SBSR_ADR_ADDR, 32'h8);
        rd(4'hD, 32'h0);
        bus(1'b1, `SBSR_ADR_IRQ_MSK, 32'h1);
        bus(1'b1, `SBSR_ADR_AMPE, 32'h20);
        bus(1'b1, `SBSR_ADR_SRE, 32'h48);
        $display("reset and setup done");
        // Second pass proves a fresh overload requests again
        repeat (2)
        begin
            pulse('{std: 8'h0, amp: 16'h0020, err: 8'h0});
            wpoll();
            chk("poll", {24'h0, pb}, {24'h0, low | 8'h48});
            chk("irq", {31'h0, irq}, 32'h1);
            @(posedge ref_clk);
            rd(`SBSR_ADR_STB, {24'h0, low | 8'h48});
            rd(`SBSR_ADR_STB, {24'h0, low | 8'h48});
            chk("srq", {31'h0, srq}, 32'h0);
            rd(`SBSR_ADR_IRQ_ST, 32'h1);
            chk("irq", {31'h0, irq}, 32'h0);
            rd(`SBSR_ADR_AMP, 32'h20);
            rd(`SBSR_ADR_STB, {24'h0, low});
            poll_req <= 1'b1;
            @(posedge ref_clk);
            poll_req <= 1'b0;
            @(posedge ref_clk);
            #1;
            chk("poll", {24'h0, pb}, {24'h0, low});
            @(posedge ref_clk);
            $display("overload pass done");
        end
        rd(`SBSR_ADR_POLL, {24'h0, low});
        rd(`SBSR_ADR_SRE, 32'h08);
        rd(`SBSR_ADR_AMPE, 32'h20);
        m = $random(seed);
        e = $random(seed);
        bus(1'b1, `SBSR_ADR_ERROR_ENABLE_WRITE, m);
        pulse('{std: 8'h0, amp: 16'h0, err: e[7:0]});
        rd(`SBSR_ADR_STB, {24'h0, low | ((|(e[7:0] & m[7:0] & 8'hFE)) ? 8'h04 : 8'h00)});
        rd(`SBSR_ADR_ERR, {24'h0, e[7:0] & 8'hFE});
        rd(`SBSR_ADR_STB, {24'h0, low});
        $display("error summary done");
        pulse('{std: e[15:8], amp: 16'h0, err: 8'h0});
        rd(`SBSR_ADR_ESR, {24'h0, e[15:8] & 8'hF5});
        rd(`SBSR_ADR_IRQ_ST, {30'h0, e[8] | e[10], 1'b0});
        bus(1'b1, `SBSR_ADR_ESE, 32'h30);
        pulse('{std: 8'h20, amp: 16'h0, err: 8'h0});
        rd(`SBSR_ADR_STB, {24'h0, low | 8'h20});
        rd(`SBSR_ADR_ESR, 32'h20);
        rd(`SBSR_ADR_STB, {24'h0, low});
        pulse('{std: 8'hF5, amp: 16'h0, err: 8'h0});
        bus(1'b1, `SBSR_ADR_CTRL, 32'h1);
        rd(`SBSR_ADR_ESR, 32'h0);
        $display("event clear done");
        bus(1'b1, `SBSR_ADR_ADDR, 32'h13);
        chk("addr", {27'h0, ba}, 32'h13);
        bus(1'b1, `SBSR_ADR_CTRL, 32'h2);
        chk("addr", {27'h0, ba}, 32'h8);
        bus(1'b1, `SBSR_ADR_ADDR, 32'h15);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        chk("addr", {27'h0, ba}, 32'h8);
        rd(`SBSR_ADR_ESR, 32'h80);
        $display("address and reset done");
        conclude();
    end
endmodule // tb
